// File: hw/keq_pkg.sv
// Shared constants and types of the key event queue readout block.
package keq_pkg;

   // ==========================================================
   // Register indexes (byte address is four times the index)
   localparam logic [6:0] IDX_INT_STAT = 7'h01;
   localparam logic [6:0] IDX_STATUS = 7'h02;
   localparam logic [6:0] IDX_SLOT_FIRST = 7'h03;
   localparam logic [6:0] IDX_POLARITY = 7'h20;
   localparam logic [6:0] IDX_INT_MASK = 7'h4e;

   // ==========================================================
   // Interrupt bit positions, shared by status and mask
   localparam int INT_EVENT_BIT = 0;
   localparam int INT_OVERRUN_BIT = 2;
   localparam logic [7:0] INT_VALID_MASK = 8'h05;

   // ==========================================================
   // Reset values
   localparam logic [7:0] INT_STAT_RST = 8'h00;
   localparam logic [7:0] INT_MASK_RST = 8'h00;
   localparam logic [20:0] POLARITY_RST = 21'h1fffff;

   // ==========================================================
   // Event codes and matrix geometry
   localparam logic [6:0] CODE_NONE = 7'h00;
   localparam logic [6:0] CODE_KEY_FIRST = 7'h01;
   localparam logic [6:0] CODE_GND_FIRST = 7'h59;
   localparam logic [6:0] CODE_GPI_FIRST = 7'h61;
   localparam logic [6:0] CODE_LOGIC_FIRST = 7'h74;
   localparam logic [6:0] CODE_WILDCARD = 7'h7f;
   localparam logic [6:0] MATRIX_COLS = 7'h0b;
   localparam logic [3:0] MATRIX_COL_LAST = 4'ha;
   localparam logic [4:0] GPI_COUNT = 5'h13;
   localparam int POL_LOGIC_BASE = 19;

   // ==========================================================
   // Carriers
   typedef struct packed {
      logic record_state_bit;
      logic [6:0] record_code_field;
   } keq_rec_t;

   typedef struct packed {
      logic [2:0] row;
      logic [3:0] col;
      logic to_ground;
      logic pressed;
   } keq_key_evt_t;

   typedef struct packed {
      logic [4:0] pin;
      logic level;
   } keq_gpi_evt_t;

   typedef struct packed {
      logic block2;
      logic level;
   } keq_logic_evt_t;

   typedef struct packed {
      logic cyc;
      logic stb;
      logic we;
      logic [8:0] adr;
      logic [3:0] sel;
      logic [31:0] dat;
   } keq_wb_req_t;

endpackage

// File: hw/keq_top.sv
// Event queue with code mapping and Wishbone register readout.
//
// Our own choice: the Wishbone slave port.
`timescale 1ns/1ns

module keq_top #(
   parameter int DEPTH = 16
) (
   input wire logic ref_clk,
   input wire logic resetn,
   input wire keq_pkg::keq_wb_req_t wb_req,
   output logic wb_ack,
   output logic [31:0] wb_dat,
   input wire logic key_valid,
   input wire keq_pkg::keq_key_evt_t key_evt,
   output logic key_ready,
   input wire logic gpi_valid,
   input wire keq_pkg::keq_gpi_evt_t gpi_evt,
   output logic gpi_ready,
   input wire logic logic_valid,
   input wire keq_pkg::keq_logic_evt_t logic_evt,
   output logic logic_ready,
   output logic irq
);

   // ==========================================================
   // State
   localparam logic [4:0] DEPTH_C = 5'(DEPTH);

   typedef struct packed {
      keq_pkg::keq_rec_t [DEPTH-1:0] q;
      logic [4:0] count;
      logic [7:0] int_stat;
      logic [7:0] int_mask;
      logic [20:0] pol;
      logic ack;
      logic [31:0] dat;
   } keq_state_t;

   keq_state_t st_ff;
   keq_state_t nxt_st;

   logic access;
   logic [6:0] idx;
   logic [6:0] slot;
   logic pop;
   logic take;
   logic legal;
   keq_pkg::keq_rec_t rec;
   logic [7:0] wr_byte;
   logic [7:0] set_bits;
   logic [7:0] clr_bits;
   logic [4:0] wr_pos;

   // ==========================================================
   // Source arbitration
   // Keys win over pins, pins over logic; a loser simply waits.
   assign key_ready = key_valid;
   assign gpi_ready = gpi_valid & ~key_valid;
   assign logic_ready = logic_valid & ~key_valid & ~gpi_valid;
   assign take = key_valid | gpi_valid | logic_valid;

   // ==========================================================
   // Record building
   always_comb begin
      rec = '0;
      legal = 1'b0;
      if (key_valid) begin
         rec.record_state_bit = key_evt.pressed;
         if (key_evt.to_ground) begin
            rec.record_code_field = keq_pkg::CODE_GND_FIRST
               + {4'h0, key_evt.row};
            legal = 1'b1;
         end else begin
            rec.record_code_field = {4'h0, key_evt.row}
               * keq_pkg::MATRIX_COLS + {3'h0, key_evt.col}
               + keq_pkg::CODE_KEY_FIRST;
            legal = key_evt.col <= keq_pkg::MATRIX_COL_LAST;
         end
      end else if (gpi_valid) begin
         rec.record_code_field = keq_pkg::CODE_GPI_FIRST
            + {2'h0, gpi_evt.pin};
         rec.record_state_bit = gpi_evt.level
            ~^ st_ff.pol[gpi_evt.pin];
         legal = gpi_evt.pin < keq_pkg::GPI_COUNT;
      end else if (logic_valid) begin
         rec.record_code_field = keq_pkg::CODE_LOGIC_FIRST
            + {6'h00, logic_evt.block2};
         rec.record_state_bit = logic_evt.level
            ~^ st_ff.pol[keq_pkg::POL_LOGIC_BASE
               + int'(logic_evt.block2)];
         legal = 1'b1;
      end
   end

   // ==========================================================
   // Bus decode
   assign access = wb_req.cyc & wb_req.stb & ~st_ff.ack;
   assign idx = wb_req.adr[8:2];
   assign slot = idx - keq_pkg::IDX_SLOT_FIRST;
   assign wr_byte = wb_req.sel[0] ? wb_req.dat[7:0] : 8'h00;

   assign pop = access & ~wb_req.we & (idx == keq_pkg::IDX_SLOT_FIRST)
      & (st_ff.count != 5'h00);

   // ==========================================================
   // Next state
   always_comb begin
      nxt_st = st_ff;
      nxt_st.ack = access;
      set_bits = 8'h00;
      clr_bits = 8'h00;
      wr_pos = st_ff.count;

      if (access && !wb_req.we) begin
         nxt_st.dat = 32'h0000_0000;
         if (idx == keq_pkg::IDX_INT_STAT) begin
            nxt_st.dat[7:0] = st_ff.int_stat;
         end else if (idx == keq_pkg::IDX_STATUS) begin
            nxt_st.dat[4:0] = st_ff.count;
         end else if (idx == keq_pkg::IDX_INT_MASK) begin
            nxt_st.dat[7:0] = st_ff.int_mask;
         end else if (idx == keq_pkg::IDX_POLARITY) begin
            nxt_st.dat[20:0] = st_ff.pol;
         end else if (idx >= keq_pkg::IDX_SLOT_FIRST
               && slot < 7'(DEPTH)) begin
            nxt_st.dat[7:0] = st_ff.q[slot[4:0]];
         end
      end

      // Slot registers ignore writes; unmapped writes are dropped.
      if (access && wb_req.we) begin
         if (idx == keq_pkg::IDX_INT_STAT) begin
            clr_bits = wr_byte;
         end else if (idx == keq_pkg::IDX_INT_MASK && wb_req.sel[0]) begin
            nxt_st.int_mask = wb_req.dat[7:0] & keq_pkg::INT_VALID_MASK;
         end else if (idx == keq_pkg::IDX_POLARITY) begin
            if (wb_req.sel[0]) begin
               nxt_st.pol[7:0] = wb_req.dat[7:0];
            end
            if (wb_req.sel[1]) begin
               nxt_st.pol[15:8] = wb_req.dat[15:8];
            end
            if (wb_req.sel[2]) begin
               nxt_st.pol[20:16] = wb_req.dat[20:16];
            end
         end
      end

      if (pop) begin
         for (int i = 0; i < DEPTH - 1; i++) begin
            nxt_st.q[i] = st_ff.q[i+1];
         end
         nxt_st.q[DEPTH-1] = '0;
         nxt_st.count = st_ff.count - 5'h01;
         wr_pos = st_ff.count - 5'h01;
      end

      if (take && legal) begin
         if (st_ff.count == DEPTH_C && !pop) begin
            set_bits[keq_pkg::INT_OVERRUN_BIT] = 1'b1;
         end else begin
            nxt_st.q[wr_pos[$clog2(DEPTH)-1:0]] = rec;
            nxt_st.count = wr_pos + 5'h01;
            set_bits[keq_pkg::INT_EVENT_BIT] = 1'b1;
         end
      end

      nxt_st.int_stat = ((st_ff.int_stat & ~clr_bits) | set_bits)
         & keq_pkg::INT_VALID_MASK;
   end

   // ==========================================================
   // Registers
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         st_ff <= '0;
         st_ff.int_stat <= keq_pkg::INT_STAT_RST;
         st_ff.int_mask <= keq_pkg::INT_MASK_RST;
         st_ff.pol <= keq_pkg::POLARITY_RST;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign wb_ack = st_ff.ack;
   assign wb_dat = st_ff.dat;
   assign irq = |(st_ff.int_stat & st_ff.int_mask);

endmodule // keq_top

// File: test/keq_host.sv
// Host model issuing classic Wishbone register cycles.
`timescale 1ns/1ns
module keq_host (
   input wire logic ref_clk,
   input wire logic wb_ack,
   input wire logic [31:0] wb_dat,
   output keq_pkg::keq_wb_req_t wb_req
);
   initial wb_req = '0;
   // Holds the request until ack is sampled, so no edge race on release.
   task automatic xfer(input logic we, input logic [8:0] a,
      input logic [31:0] wd, output logic [31:0] rd);
      @(posedge ref_clk);
      wb_req <= {2'h3, we, a, 4'h7, wd};
      do @(posedge ref_clk); while (wb_ack !== 1'b1);
      rd = wb_dat;
      wb_req <= '0;
   endtask
endmodule // keq_host

// File: test/keq_props.sv
// Checker for the register bus and event ports of the queue.
`timescale 1ns/1ns
module keq_props (
   input wire logic ref_clk,
   input wire logic resetn,
   input wire keq_pkg::keq_wb_req_t wb_req,
   input wire logic wb_ack,
   input wire logic [31:0] wb_dat,
   input wire logic key_valid,
   input wire logic key_ready,
   input wire logic gpi_valid,
   input wire logic gpi_ready,
   input wire logic logic_valid,
   input wire logic logic_ready,
   input wire logic irq
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!resetn);
   sequence take_s;
      wb_req.cyc && wb_req.stb && !wb_ack;
   endsequence
   sequence ack_s;
      wb_ack ##1 !wb_ack;
   endsequence
   ack_single_a: assert property (take_s |=> ack_s)
      else $error("bus ack missing or long");
   unmapped_zero_a: assert property ((take_s ##0 (!wb_req.we &&
      wb_req.adr[8:2] > 7'h4e)) |=> wb_dat == 32'h0)
      else $error("unmapped read not zero");
   upper_zero_a: assert property (wb_ack |-> wb_dat[31:21] == 11'h0)
      else $error("read data upper bits set");
   dat_hold_a: assert property ((!wb_ack || $past(wb_req.we))
      |-> $stable(wb_dat)) else $error("read data moved");
   key_first_a: assert property (key_ready == key_valid)
      else $error("key ready wrong");
   gpi_wait_a: assert property (gpi_ready == (gpi_valid && !key_valid))
      else $error("pin ready wrong");
   logic_wait_a: assert property (logic_ready == (logic_valid &&
      !key_valid && !gpi_valid)) else $error("logic ready wrong");
   reset_quiet_a: assert property ($rose(resetn) |-> !irq && !wb_ack)
      else $error("irq or ack after reset");
endmodule // keq_props
bind keq_top keq_props chk (.ref_clk, .resetn, .wb_req, .wb_ack, .wb_dat,
   .key_valid, .key_ready, .gpi_valid, .gpi_ready, .logic_valid,
   .logic_ready, .irq);

// File: test/keq_tb_top.sv
// Self-checking testbench of the event queue readout block.
`timescale 1ns/1ns
module keq_tb_top;
   logic ref_clk = 1'b0;
   logic resetn = 1'b0;
   logic key_valid = 1'b0;
   logic gpi_valid = 1'b0;
   logic logic_valid = 1'b0;
   keq_pkg::keq_key_evt_t key_evt = '0;
   keq_pkg::keq_gpi_evt_t gpi_evt = '0;
   keq_pkg::keq_logic_evt_t logic_evt = '0;
   keq_pkg::keq_wb_req_t wb_req;
   logic wb_ack, irq, pol;
   logic [31:0] wb_dat, v;
   logic [15:0] lf = 16'h5265;
   logic [1:0] s;
   logic [8:0] d;
   int miscompares = 0;
   int n_tests = 0;
   always #50 ref_clk = ~ref_clk;
   keq_top #(.DEPTH(16)) uut (.ref_clk, .resetn, .wb_req, .wb_ack, .wb_dat,
      .key_valid, .key_evt, .key_ready(), .gpi_valid, .gpi_evt,
      .gpi_ready(), .logic_valid, .logic_evt, .logic_ready(), .irq);
   keq_host h (.ref_clk, .wb_ack, .wb_dat, .wb_req);
   // ==========================================================
   // Helpers
   function automatic logic [15:0] nx(input logic [15:0] x);
      return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
   endfunction
   function automatic logic [7:0] xp(input logic [1:0] k,
      input logic [8:0] e, input logic p);
      if (k == 2'h0) return {e[0], e[1] ? 7'h59 + 7'(e[8:6]) :
         7'(e[8:6]) * 7'h0b + 7'(e[5:2]) + 7'h01};
      if (k == 2'h1) return {e[0] ~^ p, 7'h61 + 7'(e[5:1])};
      return {e[0] ~^ p, 7'h74 + 7'(e[1])};
   endfunction
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      n_tests++;
      if (g !== e) begin
         miscompares++;
         $display("FAIL t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic rc(input logic [8:0] a, input logic [31:0] e);
      h.xfer(1'b0, a, 32'h0, v);
      chk(v, e);
   endtask
   task automatic wr(input logic [8:0] a, input logic [31:0] wd);
      h.xfer(1'b1, a, wd, v);
   endtask
   task automatic ev(input logic [1:0] k, input logic [8:0] e);
      @(posedge ref_clk);
      key_valid <= k == 2'h0;
      gpi_valid <= k == 2'h1;
      logic_valid <= k == 2'h2;
      key_evt <= e;
      gpi_evt <= e[5:0];
      logic_evt <= e[1:0];
      @(posedge ref_clk);
      {key_valid, gpi_valid, logic_valid} <= 3'h0;
   endtask
   task automatic one(input logic [1:0] k, input logic [8:0] e);
      ev(k, e);
      @(posedge ref_clk);
      chk({31'h0, irq}, 32'h1);
      rc(9'h00c, {24'h0, xp(k, e, pol)});
      wr(9'h004, 32'h1);
      chk({31'h0, irq}, 32'h0);
   endtask
   task automatic conclude();
      $display("checks %0d mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   // A run needs about 400 cycles; this leaves ample margin.
   initial begin
      #2000000;
      miscompares++;
      conclude();
   end
   initial begin
      pol = 1'b1;
      repeat (8) @(posedge ref_clk);
      resetn <= 1'b1;
      wr(9'h138, 32'h5);
      one(2'h0, 9'h1e9);
      one(2'h0, 9'h1c2);
      one(2'h1, 9'h025);
      one(2'h2, 9'h003);
      for (int i = 0; i < 20; i++) begin
         lf = nx(lf);
         if (i == 10) begin
            wr(9'h080, 32'h0);
            pol = 1'b0;
         end
         s = 2'(lf % 3);
         d = s == 2'h1 ? {3'h0, 5'(lf[12:8] % 19), lf[3]} :
            {lf[15:13], 4'(lf[12:8] % 11), lf[2], lf[3]};
         one(s, d);
      end
      $display("test codes done");
      @(posedge ref_clk);
      {key_valid, gpi_valid} <= 2'h3;
      key_evt <= 9'h1e9;
      gpi_evt <= 6'h25;
      @(posedge ref_clk);
      key_valid <= 1'b0;
      @(posedge ref_clk);
      gpi_valid <= 1'b0;
      rc(9'h00c, {24'h0, xp(2'h0, 9'h1e9, pol)});
      rc(9'h00c, {24'h0, xp(2'h1, 9'h025, pol)});
      $display("test priority done");
      wr(9'h138, 32'h4);
      for (int k = 0; k < 17; k++) begin
         ev(2'h0, {3'(k / 11), 4'(k % 11), 2'h1});
         @(posedge ref_clk);
         chk({31'h0, irq}, {31'h0, k == 16});
      end
      rc(9'h008, 32'h10);
      rc(9'h004, 32'h5);
      wr(9'h00c, 32'hff);
      rc(9'h048, 32'h90);
      for (int k = 0; k < 16; k++) rc(9'h00c, 32'(8'h80 + k + 1));
      rc(9'h00c, 32'h0);
      rc(9'h008, 32'h0);
      rc(9'h1fc, 32'h0);
      wr(9'h004, 32'h5);
      chk({31'h0, irq}, 32'h0);
      $display("test overflow done");
      @(posedge ref_clk);
      resetn <= 1'b0;
      repeat (2) @(posedge ref_clk);
      resetn <= 1'b1;
      rc(9'h080, 32'h001f_ffff);
      rc(9'h008, 32'h0);
      $display("test reset done");
      conclude();
   end
endmodule // keq_tb_top
